//--- logic/mpm_pkg.sv
// Purpose: Constants and types for the monitor port pin mux block
// Assumes: One 25 MHz core clock, synchronous active-high reset
// Notes:   Register offsets are word indices on the plain register port
//
// Summary of operation
// - Route bits 0..3 send static PWM channels ten..thirteen to port 2 pins 4..7.
// - Port 1 pin 4 carries clamp pulse when bit 4 set and latch zero.
// - Port 1 pin 5 carries safe-area output when bit 5 set and latch zero.
// - Port 2 pin 3 carries test pattern when bit 6 set and latch zero.
// - Route register bits may be set or cleared one at a time.
// - Control five bit 6 set stops dummy vertical pulses raising the event.
// - Latch one releases the pin to its pull-up, latch zero drives it low.
// - Reading a port returns the external pin levels.
// - Port 2 pins 0..2 are plain I/O only.
// - Port 3 pin 0 is sync data in mode 0, receive input otherwise.
// - Port 3 pin 1 is sync clock in mode 0, transmit output otherwise.
// - Fourth port is seven output bits from a write-only latch.
// - Asynchronous serial reaches 19200 baud from the core clock.

package mpm_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] OFS_ROUTE  = 4'h0;
	localparam logic [3:0] OFS_CTRL5  = 4'h1;
	localparam logic [3:0] OFS_P1     = 4'h2;
	localparam logic [3:0] OFS_P2     = 4'h3;
	localparam logic [3:0] OFS_P3     = 4'h4;
	localparam logic [3:0] OFS_P4     = 4'h5;
	localparam logic [3:0] OFS_BITOP  = 4'h6;
	localparam logic [3:0] OFS_STATUS = 4'h7;
	localparam logic [3:0] OFS_MASK   = 4'h8;
	localparam logic [3:0] OFS_SMODE  = 4'h9;

	// ==========================================================
	// Field positions
	localparam int BIT_DAC0      = 0;
	localparam int BIT_CLAMP     = 4;
	localparam int BIT_SAFE      = 5;
	localparam int BIT_STP       = 6;
	localparam int BIT_INVERT_TEST_PATTERN    = 7;
	localparam int BIT_CLAMP_SRC = 5;
	localparam int BIT_DUMMY_MSK = 6;
	localparam int BIT_EV_VERT   = 0;
	localparam int BIT_EV_INT0   = 1;
	localparam int BIT_BITOP_VAL = 3;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'hFF;
	localparam logic [6:0] RST_P4    = 7'h00;
	localparam logic [1:0] RST_SMODE = 2'h0;

	// ==========================================================
	// Timing
	localparam int CLK_HZ       = 25_000_000;
	localparam int BAUD_MAX     = 19200;
	localparam int BAUD_OVERSMP = 16;
	localparam int BAUD_DIV     = CLK_HZ / (BAUD_MAX * BAUD_OVERSMP);

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} mpm_pin_drv_s;

	typedef struct packed {
		logic       txd;
		logic       sclk;
		logic       sdata;
		logic       sdata_drive;
	} mpm_serial_s;

endpackage

//--- logic/mpm_top.sv
// Purpose: Port latches, pin routing, vertical event interrupt, baud tick
// Assumes: Pins are quasi-bidirectional; board pull-ups hold released pins
// Notes:   Read data appear the cycle after the read strobe

`timescale 1ns/1ps

module mpm_top #(
	parameter int P4_WIDTH = 7,
	parameter int BAUD_CNT = mpm_pkg::BAUD_DIV
) (
	input  wire logic                 clock,        // Core clock
	input  wire logic                 rst,          // Sync reset
	input  wire logic [3:0]           reg_addr,     // Register index
	input  wire logic [7:0]           reg_wdata,    // Write data
	input  wire logic                 reg_wr,       // Write strobe
	input  wire logic                 reg_rd,       // Read strobe
	output logic      [7:0]           reg_rdata,    // Read data
	output logic                      irq,          // Level interrupt
	input  wire logic [5:0]           p1_in,        // Port 1 pins
	input  wire logic [7:0]           p2_in,        // Port 2 pins
	input  wire logic [7:0]           p3_in,        // Port 3 pins
	output mpm_pkg::mpm_pin_drv_s     p1_drv,       // Port 1 drive
	output mpm_pkg::mpm_pin_drv_s     p2_drv,       // Port 2 drive
	output mpm_pkg::mpm_pin_drv_s     p3_drv,       // Port 3 drive
	output logic [P4_WIDTH-1:0]       p4_out,       // Output-only port
	input  wire logic [3:0]           static_pwm,   // Channels ten..thirteen
	input  wire logic                 clamp_a,      // Clamp source 0
	input  wire logic                 clamp_b,      // Clamp source 1
	input  wire logic                 safe_area_in, // Safe-area signal
	input  wire logic                 stp_in,       // Test pattern
	input  wire logic                 vert_pulse,   // Real vertical event
	input  wire logic                 dummy_pulse,  // Dummy vertical event
	input  mpm_pkg::mpm_serial_s      serial,       // Serial core outputs
	output logic      [1:0]           serial_mode,  // Serial mode
	output logic                      serial_rx,    // Receive/data in
	output logic                      int0_n,       // External int level
	output logic                      t0_in,        // Timer 0 input
	output logic                      t1_in,        // Timer 1 input
	output logic                      baud_tick     // 16x baud enable
);

	// ==========================================================
	// Registers
	logic [7:0]          route_ff;
	logic [7:0]          ctrl5_ff;
	logic [7:0]          p1_latch_ff;
	logic [7:0]          p2_latch_ff;
	logic [7:0]          p3_latch_ff;
	logic [P4_WIDTH-1:0] p4_latch_ff;
	logic [1:0]          smode_ff;
	logic [1:0]          status_ff;
	logic [1:0]          mask_ff;
	logic [7:0]          rdata_ff;
	logic                irq_ff;

	// Two-stage synchronisers for pins
	logic [21:0]         pin_s1_ff;
	logic [21:0]         pin_s2_ff;
	logic                int0_prev_ff;

	logic [15:0]         baud_cnt_ff;
	logic                baud_ff;

	mpm_pkg::mpm_pin_drv_s p1_ff;
	mpm_pkg::mpm_pin_drv_s p2_ff;
	mpm_pkg::mpm_pin_drv_s p3_ff;
	mpm_pkg::mpm_pin_drv_s nxt_p1;
	mpm_pkg::mpm_pin_drv_s nxt_p2;
	mpm_pkg::mpm_pin_drv_s nxt_p3;

	logic                wr_route;
	logic                wr_bitop;
	logic [7:0]          bit_sel;
	logic [1:0]          events;
	logic [1:0]          nxt_status;
	logic                clamp_sig;
	logic                stp_sig;

	assign wr_route = reg_wr && (reg_addr == mpm_pkg::OFS_ROUTE);
	assign wr_bitop = reg_wr && (reg_addr == mpm_pkg::OFS_BITOP);
	assign bit_sel  = 8'h01 << reg_wdata[2:0];

	// ==========================================================
	// Routing control with whole-byte and single-bit writes
	always_ff @(posedge clock) begin
		if (rst) begin
			route_ff <= mpm_pkg::RST_CTRL;
		end else if (wr_route) begin
			route_ff <= reg_wdata;
		end else if (wr_bitop) begin
			// One bit changes, the rest hold
			if (reg_wdata[mpm_pkg::BIT_BITOP_VAL]) begin
				route_ff <= route_ff | bit_sel;
			end else begin
				route_ff <= route_ff & ~bit_sel;
			end
		end
	end

	// Other control registers
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl5_ff <= mpm_pkg::RST_CTRL;
			smode_ff <= mpm_pkg::RST_SMODE;
			mask_ff  <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == mpm_pkg::OFS_CTRL5) begin
				ctrl5_ff <= reg_wdata;
			end
			if (reg_addr == mpm_pkg::OFS_SMODE) begin
				smode_ff <= reg_wdata[1:0];
			end
			if (reg_addr == mpm_pkg::OFS_MASK) begin
				mask_ff <= reg_wdata[1:0];
			end
		end
	end

	// ==========================================================
	// Port latches; port 4 has no read path
	always_ff @(posedge clock) begin
		if (rst) begin
			p1_latch_ff <= mpm_pkg::RST_LATCH;
			p2_latch_ff <= mpm_pkg::RST_LATCH;
			p3_latch_ff <= mpm_pkg::RST_LATCH;
			p4_latch_ff <= P4_WIDTH'(mpm_pkg::RST_P4);
		end else if (reg_wr) begin
			if (reg_addr == mpm_pkg::OFS_P1) begin
				p1_latch_ff <= {2'h0, reg_wdata[5:0]};
			end
			if (reg_addr == mpm_pkg::OFS_P2) begin
				p2_latch_ff <= reg_wdata;
			end
			if (reg_addr == mpm_pkg::OFS_P3) begin
				p3_latch_ff <= reg_wdata;
			end
			if (reg_addr == mpm_pkg::OFS_P4) begin
				p4_latch_ff <= reg_wdata[P4_WIDTH-1:0];
			end
		end
	end

	// ==========================================================
	// Pin synchronisers; stage one feeds stage two only
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_s1_ff    <= '1;
			pin_s2_ff    <= '1;
			int0_prev_ff <= 1'b1;
		end else begin
			pin_s1_ff    <= {p3_in, p2_in, p1_in};
			pin_s2_ff    <= pin_s1_ff;
			int0_prev_ff <= pin_s2_ff[16];
		end
	end

	// ==========================================================
	// Pin drive. Latch one releases the pin to its pull-up (high),
	// latch zero pulls low; routed functions drive both ways.
	assign clamp_sig = ctrl5_ff[mpm_pkg::BIT_CLAMP_SRC] ? clamp_b : clamp_a;
	assign stp_sig   = stp_in ^ route_ff[mpm_pkg::BIT_INVERT_TEST_PATTERN];

	always_comb begin
		nxt_p1.out = 8'h00;
		nxt_p1.oe  = {2'h0, ~p1_latch_ff[5:0]};
		if (route_ff[mpm_pkg::BIT_CLAMP] && !p1_latch_ff[4]) begin
			nxt_p1.out[4] = clamp_sig;
			nxt_p1.oe[4]  = 1'b1;
		end
		if (route_ff[mpm_pkg::BIT_SAFE] && !p1_latch_ff[5]) begin
			nxt_p1.out[5] = safe_area_in;
			nxt_p1.oe[5]  = 1'b1;
		end
	end

	// Port 2: pins 0..2 are never routed
	always_comb begin
		nxt_p2.out = 8'h00;
		nxt_p2.oe  = ~p2_latch_ff;
		if (route_ff[mpm_pkg::BIT_STP] && !p2_latch_ff[3]) begin
			nxt_p2.out[3] = stp_sig;
			nxt_p2.oe[3]  = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			if (route_ff[mpm_pkg::BIT_DAC0 + i] && !p2_latch_ff[4 + i]) begin
				nxt_p2.out[4 + i] = static_pwm[i];
				nxt_p2.oe[4 + i]  = 1'b1;
			end
		end
	end

	// Port 3: function output is ANDed with a latch that software holds
	// high, so a low latch always wins and parks the pin low.
	always_comb begin
		nxt_p3.out = 8'h00;
		nxt_p3.oe  = ~p3_latch_ff;
		if (smode_ff == 2'h0) begin
			// Data line turns around under the serial core's control
			nxt_p3.oe[0] = ~p3_latch_ff[0] | (serial.sdata_drive & ~serial.sdata);
			nxt_p3.oe[1] = ~(p3_latch_ff[1] & serial.sclk);
		end else begin
			nxt_p3.oe[1] = ~(p3_latch_ff[1] & serial.txd);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			p1_ff <= '0;
			p2_ff <= '0;
			p3_ff <= '0;
		end else begin
			p1_ff <= nxt_p1;
			p2_ff <= nxt_p2;
			p3_ff <= nxt_p3;
		end
	end

	// Pin levels toward the serial, interrupt and timer logic
	always_ff @(posedge clock) begin
		if (rst) begin
			serial_rx <= 1'b1;
			int0_n    <= 1'b1;
			t0_in     <= 1'b1;
			t1_in     <= 1'b1;
		end else begin
			serial_rx <= pin_s2_ff[14];
			int0_n    <= pin_s2_ff[16];
			t0_in     <= pin_s2_ff[18];
			t1_in     <= pin_s2_ff[19];
		end
	end

	// ==========================================================
	// Events: sticky status, set wins over write-one clear
	assign events[mpm_pkg::BIT_EV_VERT] = vert_pulse |
		(dummy_pulse & ~ctrl5_ff[mpm_pkg::BIT_DUMMY_MSK]);
	assign events[mpm_pkg::BIT_EV_INT0] = int0_prev_ff & ~pin_s2_ff[16];

	always_comb begin
		nxt_status = status_ff;
		if (reg_wr && (reg_addr == mpm_pkg::OFS_STATUS)) begin
			nxt_status = status_ff & ~reg_wdata[1:0];
		end
		nxt_status = nxt_status | events;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			status_ff <= 2'h0;
			irq_ff    <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_ff    <= |(nxt_status & mask_ff);
		end
	end

	// ==========================================================
	// Baud enable; divider rounds down so the rate is never below 16x
	always_ff @(posedge clock) begin
		if (rst) begin
			baud_cnt_ff <= 16'h0000;
			baud_ff     <= 1'b0;
		end else if (baud_cnt_ff == 16'(BAUD_CNT - 1)) begin
			baud_cnt_ff <= 16'h0000;
			baud_ff     <= 1'b1;
		end else begin
			baud_cnt_ff <= baud_cnt_ff + 16'h0001;
			baud_ff     <= 1'b0;
		end
	end

	// ==========================================================
	// Read path; ports return pin levels, unmapped reads give zero
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				mpm_pkg::OFS_ROUTE:  rdata_ff <= route_ff;
				mpm_pkg::OFS_CTRL5:  rdata_ff <= ctrl5_ff;
				mpm_pkg::OFS_P1:     rdata_ff <= {2'h0, pin_s2_ff[5:0]};
				mpm_pkg::OFS_P2:     rdata_ff <= pin_s2_ff[13:6];
				mpm_pkg::OFS_P3:     rdata_ff <= pin_s2_ff[21:14];
				mpm_pkg::OFS_STATUS: rdata_ff <= {6'h00, status_ff};
				mpm_pkg::OFS_MASK:   rdata_ff <= {6'h00, mask_ff};
				mpm_pkg::OFS_SMODE:  rdata_ff <= {6'h00, smode_ff};
				default:             rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata   = rdata_ff;
	assign irq         = irq_ff;
	assign p1_drv      = p1_ff;
	assign p2_drv      = p2_ff;
	assign p3_drv      = p3_ff;
	assign p4_out      = p4_latch_ff;
	assign serial_mode = smode_ff;
	assign baud_tick   = baud_ff;

endmodule

//--- dv/mpm_monitor.sv
// Purpose: Checker for pin routing, latches, vertical irq and register port
// Assumes: Shadows follow writes with the design's register map
// Notes:   Bound into mpm_top at the foot of this file
`timescale 1ns/1ps
module mpm_monitor #(
	parameter int P4_WIDTH = 7
) (
	input wire logic                  clock,        // Core clock
	input wire logic                  rst,          // Sync reset
	input wire logic [3:0]            reg_addr,     // Index
	input wire logic [7:0]            reg_wdata,    // Write data
	input wire logic                  reg_wr,       // Write strobe
	input wire logic                  reg_rd,       // Read strobe
	input wire logic [7:0]            reg_rdata,    // Read data
	input wire logic                  irq,          // Interrupt
	input wire mpm_pkg::mpm_pin_drv_s p1_drv,       // Port 1 drive
	input wire mpm_pkg::mpm_pin_drv_s p2_drv,       // Port 2 drive
	input wire logic [P4_WIDTH-1:0]   p4_out,       // Port 4
	input wire logic [3:0]            static_pwm,   // PWM channels
	input wire logic                  clamp_a,      // Clamp 0
	input wire logic                  clamp_b,      // Clamp 1
	input wire logic                  safe_area_in, // Safe area
	input wire logic                  stp_in,       // Pattern
	input wire logic                  vert_pulse,   // Vertical
	input wire logic                  dummy_pulse   // Dummy
);
	logic [7:0] route_sh, c5_sh, p1_sh, p2_sh, mask_sh, p2_lvl;
	logic       clamp_sel, stp_x;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ==========
	// Shadows, so pin checks need no view of the bodies
	always_ff @(posedge clock) begin
		if (rst) begin
			{route_sh, c5_sh, mask_sh} <= 24'h000000;
			{p1_sh, p2_sh} <= 16'hFFFF;
		end else if (reg_wr) begin
			case (reg_addr)
				mpm_pkg::OFS_ROUTE: route_sh <= reg_wdata;
				mpm_pkg::OFS_BITOP: route_sh[reg_wdata[2:0]] <= reg_wdata[3];
				mpm_pkg::OFS_CTRL5: c5_sh <= reg_wdata;
				mpm_pkg::OFS_P1: p1_sh <= reg_wdata;
				mpm_pkg::OFS_P2: p2_sh <= reg_wdata;
				mpm_pkg::OFS_MASK: mask_sh <= reg_wdata;
				default: ;
			endcase
		end
	end
	// Selected sources and wire level of port 2
	assign clamp_sel = c5_sh[5] ? clamp_b : clamp_a;
	assign stp_x = stp_in ^ route_sh[7];
	assign p2_lvl = (p2_drv.oe & p2_drv.out) | ~p2_drv.oe;
	for (genvar i = 0; i < 4; i++) begin : g_dac
		a_dac_route: assert property (route_sh[i] && !p2_sh[i+4] |=>
			p2_drv.oe[i+4] && p2_drv.out[i+4] == $past(static_pwm[i]))
			else $error("dac pin not following its channel");
	end
	a_clamp_route: assert property (route_sh[4] && !p1_sh[4] |=>
		p1_drv.oe[4] && p1_drv.out[4] == $past(clamp_sel)) else $error("clamp pin wrong");
	a_safe_route: assert property (route_sh[5] && !p1_sh[5] |=>
		p1_drv.oe[5] && p1_drv.out[5] == $past(safe_area_in)) else $error("safe pin wrong");
	a_stp_route: assert property (route_sh[6] && !p2_sh[3] |=>
		p2_drv.oe[3] && p2_drv.out[3] == $past(stp_x)) else $error("pattern pin wrong");
	a_plain_latch: assert property (1'b1 |=>
		p2_lvl[2:0] == $past(p2_sh[2:0])) else $error("plain pin not at latch");
	a_dummy_on: assert property (dummy_pulse && !c5_sh[6] && mask_sh[0] && !reg_wr |=>
		irq) else $error("dummy pulse lost");
	a_dummy_off: assert property (dummy_pulse && c5_sh[6] && !vert_pulse && !irq
		&& !reg_wr && mask_sh == 8'h01 |=> !irq) else $error("dummy pulse not gated");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_route_read: assert property (reg_rd && reg_addr == mpm_pkg::OFS_ROUTE |=>
		reg_rdata == $past(route_sh)) else $error("route register read wrong");
	a_output_only_port_latch_load: assert property (reg_wr && reg_addr == mpm_pkg::OFS_P4 |=>
		p4_out == $past(reg_wdata[P4_WIDTH-1:0])) else $error("port 4 not loaded");
endmodule
bind mpm_top mpm_monitor #(.P4_WIDTH(P4_WIDTH)) mpm_monitor_inst (.clock, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .p1_drv, .p2_drv, .p4_out, .static_pwm,
	.clamp_a, .clamp_b, .safe_area_in, .stp_in, .vert_pulse, .dummy_pulse);

//--- dv/mpm_board.sv
// Purpose: Board side of ports 1..3: pull-ups and external pull-downs
// Assumes: A released pin floats to its pull-up unless the board pulls it
// Notes:   pull_low only acts where the device has released the pin
`timescale 1ns/1ps
module mpm_board (
	input wire mpm_pkg::mpm_pin_drv_s p1_drv,   // Port 1 drive
	input wire mpm_pkg::mpm_pin_drv_s p2_drv,   // Port 2 drive
	input wire mpm_pkg::mpm_pin_drv_s p3_drv,   // Port 3 drive
	input wire logic [7:0]            pull_low, // Board pulls low
	output logic [5:0]                p1_in,    // Port 1 wires
	output logic [7:0]                p2_in,    // Port 2 wires
	output logic [7:0]                p3_in     // Port 3 wires
);
	logic [7:0] w1;
	// ==========
	// Driver wins; a released wire shows the board level, never stale data
	assign w1 = (p1_drv.oe & p1_drv.out) | (~p1_drv.oe & ~pull_low);
	assign p1_in = w1[5:0];
	assign p2_in = (p2_drv.oe & p2_drv.out) | (~p2_drv.oe & ~pull_low);
	assign p3_in = (p3_drv.oe & p3_drv.out) | (~p3_drv.oe & ~pull_low);
endmodule

//--- dv/monitor_port_pin_mux_tb_top.sv
// Purpose: Self-checking bench for the port pin mux
// Assumes: Board model supplies pin levels; bench is the software side
// Notes:   Expected pin levels come from a small model of the routing
`timescale 1ns/1ps
module monitor_port_pin_mux_tb_top;
	logic                  clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic                  clamp_a = 1'b0, clamp_b = 1'b0, safe_area_in = 1'b0, stp_in = 1'b0;
	logic                  vert_pulse = 1'b0, dummy_pulse = 1'b0;
	logic                  irq, int0_n, t0_in, t1_in, baud_tick, serial_rx;
	logic [3:0]            reg_addr = 4'h0, static_pwm = 4'h0;
	logic [7:0]            reg_wdata = 8'h00, pull_low = 8'h00, reg_rdata, p2_in, p3_in;
	logic [7:0]            r, l1, l2, c5, e1, e2;
	logic [6:0]            p4_out;
	logic [5:0]            p1_in;
	logic [1:0]            serial_mode;
	mpm_pkg::mpm_pin_drv_s p1_drv, p2_drv, p3_drv;
	mpm_pkg::mpm_serial_s  serial = '0;
	int                    n_mismatch = 0, checked = 0, gap;
	mpm_top mpm_top_inst (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .p1_in, .p2_in, .p3_in, .p1_drv, .p2_drv, .p3_drv, .p4_out, .static_pwm,
		.clamp_a, .clamp_b, .safe_area_in, .stp_in, .vert_pulse, .dummy_pulse, .serial,
		.serial_mode, .serial_rx, .int0_n, .t0_in, .t1_in, .baud_tick);
	mpm_board mpm_board_inst (.p1_drv, .p2_drv, .p3_drv, .pull_low, .p1_in, .p2_in, .p3_in);
	// ==========
	// 25 MHz clock
	always #20 clock = ~clock;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Bus cycles: one strobe cycle, read data in the next cycle only
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// One event pulse, dummy or vertical, then the irq level
	task automatic pulse(input logic d, input logic exp);
		@(posedge clock);
		dummy_pulse <= d;
		vert_pulse <= ~d;
		@(posedge clock);
		{dummy_pulse, vert_pulse} <= 2'b00;
		#1 chk({7'h0, irq}, {7'h0, exp});
	endtask
	// Bounded wait for the baud enable; running out ends the run
	task automatic wait_tick;
		for (int i = 0; i <= 200; i++) begin
			@(posedge clock);
			#1;
			if (baud_tick === 1'b1) return;
			gap++;
		end
		n_mismatch++;
		give_verdict;
	endtask
	// Pin level: routed source, else latch over pull-up or board pull-down
	function automatic logic [7:0] pin(input logic [7:0] lat, rt, sig);
		return (rt & ~lat & sig) | (lat & ~pull_low);
	endfunction
	initial begin
		void'($urandom(32'hB333));
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rd(mpm_pkg::OFS_ROUTE, 8'h00);
		rd(mpm_pkg::OFS_P4, 8'h00);
		rd(4'hF, 8'h00);
		chk(p2_in, 8'hFF);
		$display("test 1 done");
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			wr(mpm_pkg::OFS_BITOP, 8'(8 + i));
			r[i] = 1'b1;
			rd(mpm_pkg::OFS_ROUTE, r);
		end
		wr(mpm_pkg::OFS_BITOP, 8'h02);
		rd(mpm_pkg::OFS_ROUTE, 8'hFB);
		$display("test 2 done");
		for (int k = 0; k < 40; k++) begin
			r = 8'($urandom);
			l1 = 8'($urandom);
			l2 = 8'($urandom);
			c5 = 8'($urandom) & 8'h20;
			wr(mpm_pkg::OFS_ROUTE, r);
			wr(mpm_pkg::OFS_P1, l1);
			wr(mpm_pkg::OFS_P2, l2);
			wr(mpm_pkg::OFS_CTRL5, c5);
			{static_pwm, clamp_a, clamp_b, safe_area_in, stp_in} <= 8'($urandom);
			pull_low <= 8'($urandom);
			repeat (4) @(posedge clock);
			#1;
			e2 = pin(l2, {r[3:0], r[6], 3'h0}, {static_pwm, stp_in ^ r[7], 3'h0});
			e1 = pin(l1, {2'h0, r[5:4], 4'h0}, {2'h0, safe_area_in, c5[5] ? clamp_b : clamp_a, 4'h0});
			chk(p2_in, e2);
			chk({2'h0, p1_in}, {2'h0, e1[5:0]});
			rd(mpm_pkg::OFS_P2, e2);
		end
		$display("test 3 done");
		pull_low <= 8'h00;
		wr(mpm_pkg::OFS_CTRL5, 8'h00);
		wr(mpm_pkg::OFS_MASK, 8'h01);
		wr(mpm_pkg::OFS_STATUS, 8'hFF);
		pulse(1'b1, 1'b1);
		wr(mpm_pkg::OFS_STATUS, 8'h01);
		#1 chk({7'h0, irq}, 8'h00);
		wr(mpm_pkg::OFS_CTRL5, 8'h40);
		pulse(1'b1, 1'b0);
		rd(mpm_pkg::OFS_STATUS, 8'h00);
		pulse(1'b0, 1'b1);
		wr(mpm_pkg::OFS_MASK, 8'h00);
		// Level follows a mask write one edge later
		@(posedge clock);
		#1 chk({7'h0, irq}, 8'h00);
		$display("test 4 done");
		wr(mpm_pkg::OFS_P3, 8'hFF);
		for (int m = 0; m < 4; m++) begin
			wr(mpm_pkg::OFS_SMODE, 8'(m));
			serial <= 4'($urandom);
			pull_low <= 8'($urandom) & 8'h35;
			repeat (4) @(posedge clock);
			#1;
			e1 = {6'h0, m == 0 ? serial.sclk : serial.txd,
				(m == 0 && serial.sdata_drive && !serial.sdata) ? 1'b0 : !pull_low[0]};
			chk({6'h0, p3_in[1:0]}, e1);
			chk({7'h0, serial_rx}, {7'h0, e1[0]});
			chk({6'h0, serial_mode}, 8'(m));
			chk({5'h0, int0_n, t0_in, t1_in}, {5'h0, ~pull_low[2], ~pull_low[4], ~pull_low[5]});
		end
		// Falling edge on the external interrupt pin sets status bit 1
		pull_low <= 8'h00;
		wr(mpm_pkg::OFS_MASK, 8'h02);
		wr(mpm_pkg::OFS_STATUS, 8'hFF);
		pull_low <= 8'h04;
		repeat (4) @(posedge clock);
		rd(mpm_pkg::OFS_STATUS, 8'h02);
		chk({6'h0, irq, int0_n}, 8'h02);
		$display("test 5 done");
		r = 8'($urandom) | 8'h80;
		wr(mpm_pkg::OFS_P4, r);
		#1 chk({1'b0, p4_out}, r & 8'h7F);
		rd(mpm_pkg::OFS_P4, 8'h00);
		wait_tick;
		gap = 0;
		wait_tick;
		chk(8'(gap + 1), 8'(25000000 / (19200 * 16)));
		$display("test 6 done");
		give_verdict;
	end
endmodule
